// file: sim/test_adc_sequencing_control.sv
// Self-checking bench for the converter sequencing control, driven over APB.
// Assumes zero-wait APB answers and a settled sample code before each start.
`timescale 1ns/1ns
module test_adc_sequencing_control;

    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [7:0]  sample  = 8'h00;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  chan_sel;
    logic        pwr_down;
    logic        conv_act;
    logic        irq;
    int          miscompares = 0;
    int          num_checks  = 0;
    int          n;

    // Design under test with every input driven by the bench.
    adc_sequencing_control DUT (
        .SYS_CLK_IN      (sys_clk),
        .SYS_RST_IN      (sys_rst),
        .PSEL_IN         (psel),
        .PENABLE_IN      (penable),
        .PWRITE_IN       (pwrite),
        .PADDR_IN        (paddr),
        .PWDATA_IN       (pwdata),
        .PRDATA_OUT      (prdata),
        .PREADY_OUT      (pready),
        .PSLVERR_OUT     (pslverr),
        .SAMPLE_CODE_IN  (sample),
        .CHANNEL_SEL_OUT (chan_sel),
        .POWER_DOWN_OUT  (pwr_down),
        .CONV_ACTIVE_OUT (conv_act),
        .IRQ_OUT         (irq)
    );

    // Bus clock of 125 MHz.
    always #4 sys_clk = ~sys_clk;

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Checks that a measured count lies inside a window.
    task automatic chk_range(input int v, input int lo, input int hi);
        check({31'h0000_0000, (v >= lo) && (v <= hi)}, 32'h0000_0001);
    endtask

    // One APB transfer: setup, then access held until pready is seen high.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer.
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(a, 1'b1, d, r, e);
    endtask

    // Reads a register and compares data and error response.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        xfer(a, 1'b0, 32'h0000_0000, r, e);
        check(r, exp);
        check({31'h0000_0000, e}, {31'h0000_0000, exp_err});
    endtask

    // Writes status/control and counts cycles until the converter goes idle.
    task automatic conv(input logic [7:0] sc);
        wr(adc_ctrl_pkg::OFS_SC, {24'h00_0000, sc});
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (conv_act !== 1'b0);
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the expected length of the tests.
    initial begin
        repeat (30000) @(posedge sys_clk);
        miscompares++;
        complete_run;
    end

    // Main test sequence.
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        check({31'h0000_0000, pwr_down}, 32'h0000_0001);
        rd_chk(adc_ctrl_pkg::OFS_SC, 32'h0000_001F, 1'b0);
        rd_chk(adc_ctrl_pkg::OFS_RES, 32'h0000_0000, 1'b0);
        rd_chk(adc_ctrl_pkg::OFS_CLK, 32'h0000_0000, 1'b0);
        rd_chk(adc_ctrl_pkg::OFS_MASK, 32'h0000_0000, 1'b0);
        rd_chk(8'h14, 32'h0000_0000, 1'b1);
        end_test("reset");
        // First conversion after power-off includes a settle interval.
        sample <= 8'h5A;
        conv(8'h03);
        chk_range(n, 32, 38);
        check({31'h0000_0000, pwr_down}, 32'h0000_0000);
        rd_chk(adc_ctrl_pkg::OFS_SC, 32'h0000_0083, 1'b0);
        rd_chk(adc_ctrl_pkg::OFS_RES, 32'h0000_005A, 1'b0);
        rd_chk(adc_ctrl_pkg::OFS_SC, 32'h0000_0003, 1'b0);
        wr(adc_ctrl_pkg::OFS_RES, 32'h0000_00AB);
        rd_chk(adc_ctrl_pkg::OFS_RES, 32'h0000_005A, 1'b0);
        end_test("single");
        // Prescale codes 0 to 4 and 7, so 1xx twice, with a settled channel.
        for (int p = 0; p < 8; p += (p == 4) ? 3 : 1) begin
            wr(adc_ctrl_pkg::OFS_CLK, p);
            conv(8'h03);
            chk_range(n, 16 * (1 << (p > 4 ? 4 : p)), 17 * (1 << (p > 4 ? 4 : p)) + 4);
        end
        wr(adc_ctrl_pkg::OFS_CLK, 32'h0000_0000);
        end_test("prescale");
        // External channels pass the sampled code.
        for (int c = 0; c < 7; c++) begin
            sample <= 8'h30 + 8'(c);
            conv({3'b000, 5'(c)});
            check({27'h000_0000, chan_sel}, c);
            rd_chk(adc_ctrl_pkg::OFS_RES, 32'h0000_0030 + c, 1'b0);
        end
        sample <= 8'h77;
        conv(8'h1D);
        rd_chk(adc_ctrl_pkg::OFS_RES, 32'h0000_00FF, 1'b0);
        conv(8'h1E);
        rd_chk(adc_ctrl_pkg::OFS_RES, 32'h0000_0000, 1'b0);
        end_test("channels");
        // Interrupt raised at completion, dropped by result read or write.
        conv(8'h43);
        check({31'h0000_0000, irq}, 32'h0000_0001);
        rd_chk(adc_ctrl_pkg::OFS_SC, 32'h0000_0043, 1'b0);
        rd_chk(adc_ctrl_pkg::OFS_RES, 32'h0000_0077, 1'b0);
        @(negedge sys_clk);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        conv(8'h43);
        check({31'h0000_0000, irq}, 32'h0000_0001);
        conv(8'h03);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        wr(adc_ctrl_pkg::OFS_MASK, 32'h0000_0001);
        @(negedge sys_clk);
        check({31'h0000_0000, irq}, 32'h0000_0001);
        wr(adc_ctrl_pkg::OFS_EVT, 32'h0000_0001);
        @(negedge sys_clk);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        rd_chk(adc_ctrl_pkg::OFS_EVT, 32'h0000_0000, 1'b0);
        wr(adc_ctrl_pkg::OFS_MASK, 32'h0000_0000);
        end_test("interrupt");
        // Continuous mode overwrites an unread result and keeps converting.
        sample <= 8'h11;
        wr(adc_ctrl_pkg::OFS_SC, 32'h0000_0022);
        repeat (60) @(posedge sys_clk);
        rd_chk(adc_ctrl_pkg::OFS_EVT, 32'h0000_0001, 1'b0);
        wr(adc_ctrl_pkg::OFS_EVT, 32'h0000_0001);
        sample <= 8'h22;
        repeat (60) @(posedge sys_clk);
        rd_chk(adc_ctrl_pkg::OFS_SC, 32'h0000_00A2, 1'b0);
        rd_chk(adc_ctrl_pkg::OFS_EVT, 32'h0000_0001, 1'b0);
        rd_chk(adc_ctrl_pkg::OFS_RES, 32'h0000_0022, 1'b0);
        // Single mode stops after one conversion.
        conv(8'h02);
        wr(adc_ctrl_pkg::OFS_EVT, 32'h0000_0001);
        repeat (60) @(posedge sys_clk);
        rd_chk(adc_ctrl_pkg::OFS_EVT, 32'h0000_0000, 1'b0);
        end_test("continuous");
        // Power-off code starts nothing, and the next start settles again.
        conv(8'h1F);
        check({31'h0000_0000, pwr_down}, 32'h0000_0001);
        check(n, 1);
        conv(8'h03);
        chk_range(n, 32, 38);
        end_test("power");
        complete_run;
    end

endmodule

// file: src/adc_clock_prescaler.sv
// Converter clock prescaler: one-cycle tick every 1, 2, 4, 8 or 16 bus clocks.
// Assumes the prescale code and restart come from logic on the same clock.
`timescale 1ns/1ns
module adc_clock_prescaler (
    // Clock and reset.
    input  wire logic       SYS_CLK_IN,
    input  wire logic       SYS_RST_IN,
    // Control.
    input  wire logic [2:0] PRESCALE_IN,
    input  wire logic       RESTART_IN,
    // Converter clock tick.
    output logic            TICK_OUT
);

    typedef struct packed {
        logic [3:0] cnt;
        logic       tick;
    } presc_state_t;

    localparam presc_state_t PRESC_RST = '{cnt: 4'h0, tick: 1'b0};

    presc_state_t st_q;
    presc_state_t st_d;

    // Maps the prescale code to the last count of one converter period.
    function automatic logic [3:0] div_last(input logic [2:0] code);
        logic [3:0] r;
        r = adc_ctrl_pkg::DIV16_LAST;
        case (code)
            3'h0:    r = adc_ctrl_pkg::DIV1_LAST;
            3'h1:    r = adc_ctrl_pkg::DIV2_LAST;
            3'h2:    r = adc_ctrl_pkg::DIV4_LAST;
            3'h3:    r = adc_ctrl_pkg::DIV8_LAST;
            default: r = adc_ctrl_pkg::DIV16_LAST;
        endcase
        return r;
    endfunction

    // Counts bus clocks and emits a tick at the end of each period.
    always_comb begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (RESTART_IN) begin
            st_d.cnt = 4'h0;
        end else if (st_q.cnt >= div_last(PRESCALE_IN)) begin
            st_d.cnt  = 4'h0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 4'h1;
        end
    end

    // Registers the prescaler state.
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            st_q <= PRESC_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign TICK_OUT = st_q.tick;

endmodule

// file: src/adc_ctrl_pkg.sv
// Constants shared by the converter sequencing control and its clock prescaler.
// Assumes a 32-bit APB register bus with byte addresses and 8-bit registers.
package adc_ctrl_pkg;

    // Register byte offsets on the APB bus.
    localparam int         ADDR_W   = 8;
    localparam logic [7:0] OFS_SC   = 8'h00;
    localparam logic [7:0] OFS_RES  = 8'h04;
    localparam logic [7:0] OFS_CLK  = 8'h08;
    localparam logic [7:0] OFS_EVT  = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;

    // Status/control and event register field positions.
    localparam int SC_FLAG_BIT   = 7;
    localparam int SC_IRQ_EN_BIT = 6;
    localparam int SC_CONT_BIT   = 5;
    localparam int EVT_DONE_BIT  = 0;

    // Channel codes with a special meaning.
    localparam logic [4:0] CH_LAST_EXT  = 5'h06;
    localparam logic [4:0] CH_REF_HIGH  = 5'h1D;
    localparam logic [4:0] CH_REF_LOW   = 5'h1E;
    localparam logic [4:0] CH_POWER_OFF = 5'h1F;

    // Results forced for the reference inputs.
    localparam logic [7:0] RES_REF_HIGH = 8'hFF;
    localparam logic [7:0] RES_REF_LOW  = 8'h00;

    // Reset values.
    localparam logic [4:0] CH_RESET     = 5'h1F;
    localparam logic [2:0] PRESC_RESET  = 3'h0;
    localparam logic [7:0] RES_RESET    = 8'h00;

    // Converter clock periods in one conversion and in the settle interval.
    localparam logic [4:0] CONV_TICKS = 5'h10;

    // Prescaler terminal counts for divide by 1, 2, 4, 8 and 16.
    localparam logic [3:0] DIV1_LAST  = 4'h0;
    localparam logic [3:0] DIV2_LAST  = 4'h1;
    localparam logic [3:0] DIV4_LAST  = 4'h3;
    localparam logic [3:0] DIV8_LAST  = 4'h7;
    localparam logic [3:0] DIV16_LAST = 4'hF;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SETTLE = 3'b010,
        ST_CONV   = 3'b100
    } seq_state_t;

endpackage

// file: src/adc_sequencing_control.sv
// Sequencing control around an 8-bit successive-approximation converter.
// Assumes an APB master on SYS_CLK_IN and an analog core that presents its
// code asynchronously on SAMPLE_CODE_IN.
//
// How it works
// - With interrupt enable set, each finished conversion raises the interrupt.
// - Result read or status/control write drops a pending interrupt.
// - Reset clears interrupt enable and continuous mode.
// - Continuous mode converts back to back, loading the result each time.
// - Single mode does one conversion per status/control write.
// - Channel codes 0 to 6 pick external inputs 0 to 6.
// - Codes 29 and 30 convert the high and low reference levels.
// - Codes 7 to 28 are unused and give an undefined result.
// - Channel code all ones powers the converter down.
// - First period after power-off is a settle interval, no result.
// - One 8-bit result register loaded at every completion.
// - Prescale code divides the bus clock by 1, 2, 4, 8 or 16.
// - Any status/control write with a channel code other than all ones starts a conversion.
// - A conversion lasts 16 to 17 converter clock periods.
// - Without interrupts, completion sets the flag; write or read clears it.
// - Continuous mode overwrites an unread result.
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ns
module adc_sequencing_control (
    // Clock and reset.
    input  wire logic        SYS_CLK_IN,
    input  wire logic        SYS_RST_IN,
    // APB slave.
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic [31:0]      PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    // Analog core.
    input  wire logic [7:0]  SAMPLE_CODE_IN,
    output logic [4:0]       CHANNEL_SEL_OUT,
    output logic             POWER_DOWN_OUT,
    output logic             CONV_ACTIVE_OUT,
    // Interrupt.
    output logic             IRQ_OUT
);

    typedef struct packed {
        adc_ctrl_pkg::seq_state_t fsm;
        logic [4:0]               ticks;
        logic                     conv_irq_enable;
        logic                     continuous_conv;
        logic [4:0]               input_channel_select;
        logic                     conv_complete_flag;
        logic [7:0]               result;
        logic [2:0]               conv_clock_prescale;
        logic                     evt;
        logic                     mask;
        logic                     irq_pend;
        logic                     settled;
        logic [7:0]               samp_meta;
        logic [7:0]               samp_sync;
        logic [31:0]              prdata;
    } ctrl_state_t;

    localparam ctrl_state_t CTRL_RST = '{
        fsm:                  adc_ctrl_pkg::ST_IDLE,
        ticks:                5'h00,
        conv_irq_enable:      1'b0,
        continuous_conv:      1'b0,
        input_channel_select: adc_ctrl_pkg::CH_RESET,
        conv_complete_flag:   1'b0,
        result:               adc_ctrl_pkg::RES_RESET,
        conv_clock_prescale:  adc_ctrl_pkg::PRESC_RESET,
        evt:                  1'b0,
        mask:                 1'b0,
        irq_pend:             1'b0,
        settled:              1'b0,
        samp_meta:            8'h00,
        samp_sync:            8'h00,
        prdata:               32'h0000_0000
    };

    ctrl_state_t st_q;
    ctrl_state_t st_d;
    logic        tick;
    logic        acc;
    logic        sc_wr;
    logic        res_rd;
    logic        done;
    logic        period_end;
    logic        restart;

    // True for every offset that holds a register.
    function automatic logic addr_hit(input logic [7:0] a);
        return (a == adc_ctrl_pkg::OFS_SC) || (a == adc_ctrl_pkg::OFS_RES) ||
               (a == adc_ctrl_pkg::OFS_CLK) || (a == adc_ctrl_pkg::OFS_EVT) ||
               (a == adc_ctrl_pkg::OFS_MASK);
    endfunction

    // Builds the status/control byte.
    function automatic logic [7:0] sc_byte(input ctrl_state_t s);
        logic [7:0] b;
        b = {3'h0, s.input_channel_select};
        b[adc_ctrl_pkg::SC_FLAG_BIT]   = s.conv_complete_flag;
        b[adc_ctrl_pkg::SC_IRQ_EN_BIT] = s.conv_irq_enable;
        b[adc_ctrl_pkg::SC_CONT_BIT] = s.continuous_conv;
        return b;
    endfunction

    // Picks the code loaded at completion for the selected channel.
    function automatic logic [7:0] conv_value(input logic [4:0] ch, input logic [7:0] core);
        logic [7:0] v;
        v = core;
        if (ch == adc_ctrl_pkg::CH_REF_HIGH) begin
            v = adc_ctrl_pkg::RES_REF_HIGH;
        end else if (ch == adc_ctrl_pkg::CH_REF_LOW) begin
            v = adc_ctrl_pkg::RES_REF_LOW;
        end
        return v;
    endfunction

    // Converter clock ticks from the prescaler.
    adc_clock_prescaler u_presc (
        .SYS_CLK_IN  (SYS_CLK_IN),
        .SYS_RST_IN  (SYS_RST_IN),
        .PRESCALE_IN (st_q.conv_clock_prescale),
        .RESTART_IN  (restart),
        .TICK_OUT    (tick)
    );

    // Bus decode and sequencer events.
    assign acc        = PSEL_IN && PENABLE_IN;
    assign sc_wr      = acc && PWRITE_IN && (PADDR_IN == adc_ctrl_pkg::OFS_SC);
    assign res_rd     = acc && !PWRITE_IN && (PADDR_IN == adc_ctrl_pkg::OFS_RES);
    assign period_end = tick && (st_q.ticks == (adc_ctrl_pkg::CONV_TICKS - 5'h01));
    assign done       = (st_q.fsm == adc_ctrl_pkg::ST_CONV) && period_end;
    assign restart    = sc_wr;

    // Next-state logic for sequencer, registers, flags and read data.
    always_comb begin
        st_d           = st_q;
        st_d.samp_meta = SAMPLE_CODE_IN;
        st_d.samp_sync = st_q.samp_meta;
        // Sequencer advance on converter clock ticks.
        case (st_q.fsm)
            adc_ctrl_pkg::ST_IDLE: begin
                st_d.ticks = 5'h00;
            end
            adc_ctrl_pkg::ST_SETTLE: begin
                if (tick) begin
                    st_d.ticks = st_q.ticks + 5'h01;
                end
                if (period_end) begin
                    st_d.fsm     = adc_ctrl_pkg::ST_CONV;
                    st_d.ticks   = 5'h00;
                    st_d.settled = 1'b1;
                end
            end
            adc_ctrl_pkg::ST_CONV: begin
                if (tick) begin
                    st_d.ticks = st_q.ticks + 5'h01;
                end
                if (done) begin
                    st_d.ticks  = 5'h00;
                    st_d.result = conv_value(st_q.input_channel_select,
                                             st_q.samp_sync);
                    if (st_q.continuous_conv) begin
                        st_d.fsm = adc_ctrl_pkg::ST_CONV;
                    end else begin
                        st_d.fsm = adc_ctrl_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                st_d.fsm   = adc_ctrl_pkg::ST_IDLE;
                st_d.ticks = 5'h00;
            end
        endcase
        // Register writes; a status/control write restarts the sequencer.
        if (acc && PWRITE_IN) begin
            case (PADDR_IN)
                adc_ctrl_pkg::OFS_SC: begin
                    st_d.conv_irq_enable      = PWDATA_IN[adc_ctrl_pkg::SC_IRQ_EN_BIT];
                    st_d.continuous_conv      = PWDATA_IN[adc_ctrl_pkg::SC_CONT_BIT];
                    st_d.input_channel_select = PWDATA_IN[4:0];
                    st_d.ticks                = 5'h00;
                    if (PWDATA_IN[4:0] == adc_ctrl_pkg::CH_POWER_OFF) begin
                        st_d.fsm     = adc_ctrl_pkg::ST_IDLE;
                        st_d.settled = 1'b0;
                    end else if (st_q.settled) begin
                        st_d.fsm = adc_ctrl_pkg::ST_CONV;
                    end else begin
                        st_d.fsm = adc_ctrl_pkg::ST_SETTLE;
                    end
                end
                adc_ctrl_pkg::OFS_CLK: begin
                    st_d.conv_clock_prescale = PWDATA_IN[2:0];
                end
                adc_ctrl_pkg::OFS_EVT: begin
                    if (PWDATA_IN[adc_ctrl_pkg::EVT_DONE_BIT]) begin
                        st_d.evt = 1'b0;
                    end
                end
                adc_ctrl_pkg::OFS_MASK: begin
                    st_d.mask = PWDATA_IN[adc_ctrl_pkg::EVT_DONE_BIT];
                end
                default: begin
                    st_d.mask = st_q.mask;
                end
            endcase
        end
        // Completion flag and pending request: clear on status/control write or result read, set wins.
        if (sc_wr || res_rd) begin
            st_d.conv_complete_flag = 1'b0;
            st_d.irq_pend           = 1'b0;
        end
        if (done && !st_q.conv_irq_enable) begin
            st_d.conv_complete_flag = 1'b1;
        end
        if (done && st_q.conv_irq_enable) begin
            st_d.irq_pend = 1'b1;
        end
        if (done) begin
            st_d.evt = 1'b1;
        end
        // Read data is captured in the setup phase.
        if (PSEL_IN && !PENABLE_IN) begin
            case (PADDR_IN)
                adc_ctrl_pkg::OFS_SC:   st_d.prdata = {24'h00_0000, sc_byte(st_q)};
                adc_ctrl_pkg::OFS_RES:  st_d.prdata = {24'h00_0000, st_q.result};
                adc_ctrl_pkg::OFS_CLK:  st_d.prdata = {29'h0000_0000, st_q.conv_clock_prescale};
                adc_ctrl_pkg::OFS_EVT:  st_d.prdata = {31'h0000_0000, st_q.evt};
                adc_ctrl_pkg::OFS_MASK: st_d.prdata = {31'h0000_0000, st_q.mask};
                default:                st_d.prdata = 32'h0000_0000;
            endcase
        end
    end

    // Registers the whole control state.
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            st_q <= CTRL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Bus answers with no wait states; unmapped offsets report an error.
    assign PREADY_OUT  = 1'b1;
    assign PSLVERR_OUT = acc && !addr_hit(PADDR_IN);
    assign PRDATA_OUT  = st_q.prdata;

    // Analog core controls and interrupt line.
    assign CHANNEL_SEL_OUT = st_q.input_channel_select;
    assign POWER_DOWN_OUT  = (st_q.input_channel_select == adc_ctrl_pkg::CH_POWER_OFF);
    assign CONV_ACTIVE_OUT = (st_q.fsm != adc_ctrl_pkg::ST_IDLE);
    assign IRQ_OUT         = st_q.irq_pend || (st_q.evt && st_q.mask);

    // Checks on the sequencer and flags.
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    AST_IRQ_ON_DONE: assert property (done && st_q.conv_irq_enable |=> IRQ_OUT)
        else $error("Interrupt not raised after completion.");
    AST_PEND_CLEAR: assert property (sc_wr && !done |=> !st_q.irq_pend)
        else $error("Pending request survived a control write.");
    AST_RESET_CLEAR: assert property (disable iff (1'b0)
        SYS_RST_IN |=> !st_q.conv_irq_enable && !st_q.continuous_conv)
        else $error("Reset left enable or continuous bit set.");
    AST_CONT_RELOAD: assert property (done && st_q.continuous_conv && !sc_wr
        |=> st_q.fsm == adc_ctrl_pkg::ST_CONV && st_q.ticks == 5'h00)
        else $error("Continuous mode did not restart.");
    AST_SINGLE_STOP: assert property (done && !st_q.continuous_conv && !sc_wr
        |=> st_q.fsm == adc_ctrl_pkg::ST_IDLE
        ##1 (st_q.fsm == adc_ctrl_pkg::ST_IDLE || $past(sc_wr)))
        else $error("Single mode kept converting.");
    AST_REF_HIGH: assert property (done && st_q.input_channel_select == adc_ctrl_pkg::CH_REF_HIGH
        |=> st_q.result == adc_ctrl_pkg::RES_REF_HIGH)
        else $error("High reference did not give full scale.");
    AST_POWER_OFF: assert property (POWER_DOWN_OUT && !$past(sc_wr)
        |-> st_q.fsm == adc_ctrl_pkg::ST_IDLE)
        else $error("Converter active while powered off.");
    AST_SETTLE_NO_LOAD: assert property (st_q.fsm == adc_ctrl_pkg::ST_SETTLE && !sc_wr
        |=> $stable(st_q.result) && (!st_q.evt || $past(st_q.evt)))
        else $error("Result loaded during settle interval.");
    AST_RESULT_LOAD: assert property (done && st_q.input_channel_select <= adc_ctrl_pkg::CH_LAST_EXT
        |=> st_q.result == $past(st_q.samp_sync))
        else $error("Result not loaded from the core.");
    AST_DONE_FLAG_SET: assert property (done && !st_q.conv_irq_enable
        |=> st_q.conv_complete_flag)
        else $error("Completion flag not set.");
    AST_CONV_START: assert property (sc_wr && PWDATA_IN[4:0] != adc_ctrl_pkg::CH_POWER_OFF
        |=> st_q.fsm != adc_ctrl_pkg::ST_IDLE && st_q.ticks == 5'h00)
        else $error("Write did not start a conversion.");

    COV_SINGLE: cover property (done && !st_q.continuous_conv);
    COV_CONT: cover property (done && st_q.continuous_conv ##[1:600] done);
    COV_IRQ: cover property (done && st_q.conv_irq_enable ##1 IRQ_OUT ##[1:50] !IRQ_OUT);

endmodule
